// >>> rtl/fes_host.sv
`timescale 1ns/1ps
`default_nettype none
module fes_host #(
    parameter int ADDR_W = 19,
    parameter logic [18:0] UNLOCK1_ADDR = 19'h00555,
    parameter logic [7:0] UNLOCK1_DATA = 8'hAA,
    parameter logic [18:0] UNLOCK2_ADDR = 19'h002AA,
    parameter logic [7:0] UNLOCK2_DATA = 8'h55
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output var fes_pkg::fes_pins_t flash_o,
    input wire logic [7:0] flash_dq_i
);
    if (ADDR_W != 19) begin : g_chk
        $error("fes_host supports a 19-bit flash address only");
    end

    fes_pkg::fes_state_t state;
    logic [2:0] op;
    logic [2:0] step;
    logic [18:0] op_addr;
    logic [7:0] rd_data;
    logic [7:0] prev_data;
    logic prev_valid;
    logic aborting;
    logic busy;
    logic done;
    logic fail;
    logic late;
    logic win_open;
    logic [11:0] win_cnt;
    logic [3:0] cyc_cnt;
    logic is_write;
    logic wb_req;

    // Decision of the next flash cycle
    logic act_wr;
    logic act_rd;
    logic act_end;
    logic act_fail;
    logic [18:0] act_addr;
    logic [7:0] act_data;
    logic poll_ok;
    logic poll_to;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign poll_ok = prev_valid && rd_data[fes_pkg::POLL_BIT] &&
        (rd_data[fes_pkg::TOGGLE_BIT] == prev_data[fes_pkg::TOGGLE_BIT]);
    assign poll_to = rd_data[fes_pkg::TIMEOUT_FLAG_BIT];

    always_comb begin
        act_wr = 1'b0;
        act_rd = 1'b0;
        act_end = 1'b0;
        act_fail = 1'b0;
        act_addr = op_addr;
        act_data = fes_pkg::CMD_RESET;
        case (op)
            fes_pkg::OP_READ: begin
                if (step == 3'h0) begin
                    act_rd = 1'b1;
                end else begin
                    act_end = 1'b1;
                end
            end
            fes_pkg::OP_RESET: begin
                if (step == 3'h0) begin
                    act_wr = 1'b1;
                end else begin
                    act_end = 1'b1;
                end
            end
            fes_pkg::OP_ERASE: begin
                act_wr = 1'b1;
                case (step)
                    3'h0, 3'h3: begin
                        act_addr = UNLOCK1_ADDR;
                        act_data = UNLOCK1_DATA;
                    end
                    3'h1, 3'h4: begin
                        act_addr = UNLOCK2_ADDR;
                        act_data = UNLOCK2_DATA;
                    end
                    3'h2: begin
                        act_addr = UNLOCK1_ADDR;
                        act_data = fes_pkg::CMD_SETUP;
                    end
                    3'h5: begin
                        act_data = fes_pkg::CMD_SECTOR;
                    end
                    default: begin
                        act_wr = 1'b0;
                        act_end = 1'b1;
                    end
                endcase
            end
            fes_pkg::OP_LOAD: begin
                if (step == 3'h0 && win_open) begin
                    act_wr = 1'b1;
                    act_data = fes_pkg::CMD_SECTOR;
                end else begin
                    act_end = 1'b1;
                    act_fail = (step == 3'h0);
                end
            end
            default: begin
                if (aborting) begin
                    act_end = 1'b1;
                    act_fail = 1'b1;
                end else if (step != 3'h0 && poll_ok) begin
                    act_end = 1'b1;
                end else if (step != 3'h0 && poll_to) begin
                    act_wr = 1'b1;
                end else begin
                    act_rd = 1'b1;
                end
            end
        endcase
    end

    // Flash cycle sequencer and pin drive
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= fes_pkg::S_IDLE;
            flash_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1, addr: '0, dq: '0};
            cyc_cnt <= 4'h0;
            step <= 3'h0;
            is_write <= 1'b0;
            aborting <= 1'b0;
        end else begin
            case (state)
                fes_pkg::S_IDLE: begin
                    if (wb_req && wb_we_i && wb_adr_i == fes_pkg::REG_CTRL && wb_sel_i[0] &&
                        wb_dat_i[2:0] >= fes_pkg::OP_READ && wb_dat_i[2:0] <= fes_pkg::OP_POLL) begin
                        state <= fes_pkg::S_DECIDE;
                        step <= 3'h0;
                        aborting <= 1'b0;
                    end
                end
                fes_pkg::S_DECIDE: begin
                    cyc_cnt <= 4'h0;
                    flash_o.addr <= act_addr;
                    flash_o.dq <= act_data;
                    if (act_wr) begin
                        state <= fes_pkg::S_WRITE;
                        is_write <= 1'b1;
                        aborting <= (op == fes_pkg::OP_POLL);
                        flash_o.ce_n <= 1'b0;
                        flash_o.we_n <= 1'b0;
                        flash_o.dq_oe_n <= 1'b0;
                    end else if (act_rd) begin
                        state <= fes_pkg::S_READ;
                        is_write <= 1'b0;
                        flash_o.ce_n <= 1'b0;
                        flash_o.oe_n <= 1'b0;
                    end else begin
                        state <= fes_pkg::S_IDLE;
                    end
                end
                fes_pkg::S_WRITE: begin
                    cyc_cnt <= cyc_cnt + 4'h1;
                    if (cyc_cnt == 4'(fes_pkg::WR_CYC - 1)) begin
                        state <= fes_pkg::S_GAP;
                        cyc_cnt <= 4'h0;
                        flash_o.ce_n <= 1'b1;
                        flash_o.we_n <= 1'b1;
                    end
                end
                fes_pkg::S_READ: begin
                    cyc_cnt <= cyc_cnt + 4'h1;
                    if (cyc_cnt == 4'(fes_pkg::RD_CYC - 1)) begin
                        state <= fes_pkg::S_GAP;
                        cyc_cnt <= 4'h0;
                        flash_o.ce_n <= 1'b1;
                        flash_o.oe_n <= 1'b1;
                    end
                end
                default: begin
                    cyc_cnt <= cyc_cnt + 4'h1;
                    if (cyc_cnt == 4'(fes_pkg::REC_CYC - 1)) begin
                        state <= fes_pkg::S_DECIDE;
                        step <= step + 3'h1;
                        flash_o.dq_oe_n <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Read data capture for status polling
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data <= 8'h00;
            prev_data <= 8'h00;
            prev_valid <= 1'b0;
        end else if (state == fes_pkg::S_IDLE) begin
            prev_valid <= 1'b0;
        end else if (state == fes_pkg::S_READ && cyc_cnt == 4'(fes_pkg::RD_CYC - 1)) begin
            rd_data <= flash_dq_i;
            prev_data <= rd_data;
            prev_valid <= (step != 3'h0);
        end
    end

    // Sector-load window timer
    always_ff @(posedge clk) begin
        if (reset) begin
            win_open <= 1'b0;
            win_cnt <= 12'h000;
        end else if (state == fes_pkg::S_WRITE && cyc_cnt == 4'(fes_pkg::WR_CYC - 1)) begin
            win_open <= (op == fes_pkg::OP_LOAD) || (op == fes_pkg::OP_ERASE && step == 3'h5);
            win_cnt <= 12'h000;
        end else if (win_open) begin
            win_cnt <= win_cnt + 12'h001;
            if (win_cnt == 12'(fes_pkg::WIN_CYC - 1)) begin
                win_open <= 1'b0;
            end
        end
    end

    // Operation status
    always_ff @(posedge clk) begin
        if (reset) begin
            op <= 3'h0;
            busy <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            late <= 1'b0;
        end else if (state == fes_pkg::S_IDLE) begin
            if (wb_req && wb_we_i && wb_adr_i == fes_pkg::REG_CTRL && wb_sel_i[0] &&
                wb_dat_i[2:0] >= fes_pkg::OP_READ && wb_dat_i[2:0] <= fes_pkg::OP_POLL) begin
                op <= wb_dat_i[2:0];
                busy <= 1'b1;
                done <= 1'b0;
                fail <= 1'b0;
                late <= 1'b0;
            end
        end else if (state == fes_pkg::S_DECIDE && act_end) begin
            busy <= 1'b0;
            done <= 1'b1;
            fail <= act_fail;
            late <= act_fail && (op == fes_pkg::OP_LOAD);
        end
    end

    // Wishbone slave, one-cycle answer
    always_ff @(posedge clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            op_addr <= 19'h00000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && wb_we_i && wb_adr_i == fes_pkg::REG_ADDR && !busy) begin
                if (wb_sel_i[0]) begin
                    op_addr[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    op_addr[15:8] <= wb_dat_i[15:8];
                end
                if (wb_sel_i[2]) begin
                    op_addr[18:16] <= wb_dat_i[18:16];
                end
            end
            if (wb_req && !wb_we_i) begin
                if (wb_adr_i == fes_pkg::REG_CTRL) begin
                    wb_dat_o <= {29'h0, op};
                end else if (wb_adr_i == fes_pkg::REG_ADDR) begin
                    wb_dat_o <= {13'h0, op_addr};
                end else if (wb_adr_i == fes_pkg::REG_STATUS) begin
                    wb_dat_o <= {27'h0, late, win_open, fail, done, busy};
                end else if (wb_adr_i == fes_pkg::REG_DATA) begin
                    wb_dat_o <= {24'h0, rd_data};
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/fes_pkg.sv
package fes_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // Flash bus cycle timing
    localparam int T_ACC_NS = 90;
    localparam int RD_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_WP_NS = 35;
    localparam int WR_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_REC_NS = 20;
    localparam int REC_CYC = (T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Sector-load window, longest time so rounded down
    localparam int T_WIN_US = 50;
    localparam int WIN_CYC = T_WIN_US * 1000 / CLK_PERIOD_NS;
    // Device command codes
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_SETUP = 8'h80;
    localparam logic [7:0] CMD_SECTOR = 8'h30;
    // Device status bit positions
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int TIMEOUT_FLAG_BIT = 5;
    localparam int ERASE_WINDOW_BIT = 3;
    // Wishbone register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_DATA = 4'hC;
    // Operation codes written to CTRL[2:0]
    localparam logic [2:0] OP_READ = 3'h1;
    localparam logic [2:0] OP_RESET = 3'h2;
    localparam logic [2:0] OP_ERASE = 3'h3;
    localparam logic [2:0] OP_LOAD = 3'h4;
    localparam logic [2:0] OP_POLL = 3'h5;
    // STATUS bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_WIN = 3;
    localparam int ST_LATE = 4;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe_n;
        logic [18:0] addr;
        logic [7:0] dq;
    } fes_pins_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_DECIDE = 5'h02,
        S_WRITE = 5'h04,
        S_READ = 5'h08,
        S_GAP = 5'h10
    } fes_state_t;
endpackage

// >>> dv/fes_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fes_host_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire fes_pkg::fes_pins_t flash_o,
    input wire logic [7:0] flash_dq_i
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after request");
    a_ack_pulse: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_write_strobes: assert property (!flash_o.we_n |-> !flash_o.ce_n && flash_o.oe_n && !flash_o.dq_oe_n)
        else $error("write strobe without select or data");
    a_write_pulse: assert property ($fell(flash_o.we_n) |-> ##1 !flash_o.we_n ##1 flash_o.we_n)
        else $error("write pulse length wrong");
    a_write_gap: assert property ($rose(flash_o.we_n) |-> flash_o.we_n ##1 flash_o.we_n)
        else $error("write recovery too short");
    a_addr_held: assert property (!flash_o.we_n && !$past(flash_o.we_n) |-> $stable(flash_o.addr) && $stable(flash_o.dq))
        else $error("address or data moved in write");
    a_read_pulse: assert property ($fell(flash_o.oe_n) |-> (!flash_o.oe_n && flash_o.dq_oe_n)[*5] ##1 flash_o.oe_n)
        else $error("read strobe length wrong");
    a_read_addr: assert property (!flash_o.oe_n && !$past(flash_o.oe_n) |-> $stable(flash_o.addr))
        else $error("address moved in read");
    c_sector_code: cover property ($rose(flash_o.we_n) && flash_o.dq == 8'h30);
    c_read: cover property ($fell(flash_o.oe_n));
    c_wb_read: cover property (wb_ack_o && !wb_we_i);
endmodule
`default_nettype wire

// >>> dv/fes_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fes_flash_model #(
    parameter logic [18:0] U1A = 19'h00555,
    parameter logic [7:0] U1D = 8'hAA,
    parameter logic [18:0] U2A = 19'h002AA,
    parameter logic [7:0] U2D = 8'h55,
    parameter int WIN = 2500
) (
    input wire logic clk,
    input wire fes_pkg::fes_pins_t pins,
    input wire logic [11:0] erase_len,
    input wire logic stuck,
    output logic [7:0] dq,
    output logic busy = 1'b0,
    output logic [3:0] loads = 4'h0
);
    logic [2:0] seq = 3'h0;
    logic win = 1'b0;
    logic tflag = 1'b0;
    logic tog = 1'b0;
    logic pwe = 1'b1;
    logic poe = 1'b1;
    logic ok;
    logic [18:0] la = 19'h0;
    logic [11:0] cnt = 12'h0;
    logic [7:0] last_q = 8'h0;
    logic [7:0] val;
    wire rd = !pins.ce_n && !pins.oe_n;
    // Status while busy, poll bit is complement of erased ones
    assign val = busy ? {1'b0, tog, tflag, 1'b0, !win, 3'h0} : (pins.addr[7:0] | 8'h80);
    // Released bus shows inverse of last byte
    assign dq = rd ? val : ~last_q;
    always_comb begin
        case (seq)
            3'h0, 3'h3: ok = la == U1A && pins.dq == U1D;
            3'h1, 3'h4: ok = la == U2A && pins.dq == U2D;
            3'h2: ok = la == U1A && pins.dq == 8'h80;
            default: ok = pins.dq == 8'h30;
        endcase
    end
    always @(posedge clk) begin
        pwe <= pins.we_n;
        poe <= pins.oe_n;
        if (rd) last_q <= val;
        if (poe && !pins.oe_n && busy) tog <= !tog;
        if (pwe && !pins.we_n) la <= pins.addr;
        if (busy && !tflag) begin
            cnt <= cnt + 12'h1;
            if (win && cnt == 12'(WIN - 1)) begin
                win <= 1'b0;
                cnt <= 12'h0;
            end else if (!win && cnt == erase_len) begin
                tflag <= stuck;
                busy <= stuck;
            end
        end
        if (!pwe && pins.we_n) begin
            if (win) begin
                if (pins.dq == 8'h30) begin
                    cnt <= 12'h0;
                    loads <= loads + 4'h1;
                end else if (pins.dq != 8'hB0) begin
                    win <= 1'b0;
                    busy <= 1'b0;
                end
            end else if (busy) begin
                if (tflag && pins.dq == 8'hF0) begin
                    busy <= 1'b0;
                    tflag <= 1'b0;
                end
            end else begin
                // Sequence step, stray or reset write restarts it
                seq <= ok ? seq + 3'h1 : 3'h0;
                if (ok && seq == 3'h5) begin
                    seq <= 3'h0;
                    win <= 1'b1;
                    busy <= 1'b1;
                    cnt <= 12'h0;
                    loads <= 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] dato;
    logic [31:0] rdat;
    logic [31:0] st;
    logic ack;
    logic stuck = 1'b0;
    logic fbusy;
    logic [3:0] loads;
    logic [7:0] fdq;
    fes_pkg::fes_pins_t pins;
    int fails = 0;
    int tests_run = 0;
    always #10 clk = ~clk;
    fes_host dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(dato), .wb_ack_o(ack), .flash_o(pins), .flash_dq_i(fdq));
    fes_flash_model flash (.clk(clk), .pins(pins), .erase_len(12'h12C), .stuck(stuck), .dq(fdq),
        .busy(fbusy), .loads(loads));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            chk("ack wait", 32'h0, 32'h1);
            end_of_test;
        end
    endtask
    task automatic run_op(input logic [18:0] a, input logic [2:0] op);
        int n;
        n = 0;
        wb(1'b1, fes_pkg::REG_ADDR, {13'h0, a});
        wb(1'b1, fes_pkg::REG_CTRL, {29'h0, op});
        do begin
            wb(1'b0, fes_pkg::REG_STATUS, 32'h0);
            n++;
        end while (rdat[fes_pkg::ST_BUSY] !== 1'b0 && n < 2000);
        st = rdat;
        if (n >= 2000) begin
            chk("busy wait", 32'h0, 32'h1);
            end_of_test;
        end
    endtask
    task automatic t_regs;
        wb(1'b0, fes_pkg::REG_STATUS, 32'h0);
        chk("status", rdat, 32'h0);
        wb(1'b1, fes_pkg::REG_STATUS, 32'h1F);
        wb(1'b0, 4'h2, 32'h0);
        chk("unmapped", rdat, 32'h0);
        wb(1'b0, fes_pkg::REG_STATUS, 32'h0);
        chk("status ro", rdat, 32'h0);
        wb(1'b1, fes_pkg::REG_CTRL, 32'h7);
        wb(1'b0, fes_pkg::REG_CTRL, 32'h0);
        chk("bad op ignored", rdat, 32'h0);
        wb(1'b0, fes_pkg::REG_STATUS, 32'h0);
        chk("bad op idle", rdat, 32'h0);
    endtask
    task automatic t_read;
        run_op(19'h12345, fes_pkg::OP_READ);
        chk("read status", st[4:0], 5'h02);
        wb(1'b0, fes_pkg::REG_DATA, 32'h0);
        chk("array byte", rdat[7:0], 8'hC5);
        wb(1'b0, fes_pkg::REG_CTRL, 32'h0);
        chk("ctrl readback", rdat, 32'h1);
        wb(1'b0, fes_pkg::REG_ADDR, 32'h0);
        chk("addr readback", rdat, 32'h12345);
    endtask
    task automatic t_erase;
        run_op(19'h30000, fes_pkg::OP_ERASE);
        chk("erase status", st[4:0], 5'h0A);
        chk("sector list", loads, 4'h1);
        run_op(19'h40000, fes_pkg::OP_LOAD);
        chk("load status", st[4:0], 5'h0A);
        chk("sector list", loads, 4'h2);
        chk("erasing", fbusy, 1'b1);
        run_op(19'h30000, fes_pkg::OP_POLL);
        chk("poll status", st[4:0], 5'h02);
        chk("erase ended", fbusy, 1'b0);
        run_op(19'h30000, fes_pkg::OP_LOAD);
        chk("late load", st[4:0], 5'h16);
        t_read;
    endtask
    task automatic t_abort;
        run_op(19'h60000, fes_pkg::OP_ERASE);
        run_op(19'h7FFFF, fes_pkg::OP_RESET);
        chk("reset status", st[4:0], 5'h02);
        chk("window abort", fbusy, 1'b0);
    endtask
    task automatic t_timeout;
        stuck <= 1'b1;
        run_op(19'h50000, fes_pkg::OP_ERASE);
        run_op(19'h50000, fes_pkg::OP_POLL);
        chk("timeout status", st[4:0], 5'h06);
        chk("reset after timeout", fbusy, 1'b0);
        stuck <= 1'b0;
        t_read;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        t_read;
        t_erase;
        t_abort;
        t_timeout;
        end_of_test;
    end
endmodule
bind fes_host fes_host_properties props (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .flash_o(flash_o), .flash_dq_i(flash_dq_i));
`default_nettype wire
